// ==== hdl/buf_ctrl_pkg.sv ====
// Constants, field positions, reset values and state codes for the buffer control port.
// Assumes one control port per device, 8-bit register indices.
package buf_ctrl_pkg;
    localparam logic [6:0] SLAVE_ADDR  = 7'h6C;
    localparam logic [7:0] IDX_MODE    = 8'h00;
    localparam logic [7:0] IDX_EN_LO   = 8'h01;
    localparam logic [7:0] IDX_EN_HI   = 8'h02;
    localparam logic [7:0] IDX_SPARE   = 8'h03;
    localparam logic [7:0] IDX_BCNT    = 8'h07;
    localparam int         BIT_RB_HI   = 7;
    localparam int         BIT_RB_LO   = 6;
    localparam int         BIT_OVR     = 3;
    localparam int         BIT_SW_HI   = 2;
    localparam int         BIT_SW_LO   = 1;
    localparam int         EN0_POS     = 1;
    localparam int         EN1_POS     = 2;
    localparam int         EN2_POS     = 5;
    localparam int         EN3_POS     = 6;
    localparam int         EN4_POS     = 1;
    localparam int         EN5_POS     = 2;
    localparam int         BCNT_W      = 5;
    localparam logic [7:0] EN_LO_RSV   = 8'h99;
    localparam logic [7:0] EN_HI_RSV   = 8'h08;
    localparam logic       OVR_RST     = 1'b0;
    localparam logic [1:0] SW_RST      = 2'h3;
    localparam logic [5:0] EN_RST      = 6'h3F;
    localparam logic [4:0] BCNT_RST    = 5'h08;
    localparam logic [1:0] MODE_LO_BW  = 2'h0;
    localparam logic [1:0] MODE_BYPASS = 2'h1;
    localparam logic [1:0] MODE_HI_BW  = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [3:0] BITS_BYTE   = 4'h8;
    localparam logic [3:0] BIT_LAST_TX = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX   = 3'h1,
        ST_ACK  = 3'h3,
        ST_TX   = 3'h2,
        ST_HACK = 3'h6
    } link_state_e;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'h0,
        PH_INDEX = 2'h1,
        PH_COUNT = 2'h3,
        PH_WDATA = 2'h2
    } rx_phase_e;
endpackage : buf_ctrl_pkg

// ==== hdl/buf_ctrl_top.sv ====
// Control port of a six-output clock buffer: bus slave, registers, output gating.
// Assumes link_clk_i oversamples the serial clock at least four times.
`timescale 1ns/1ps
// Overview of operation
// - Start plus matching address with write bit is acknowledged.
// - Next byte is the starting index, acknowledged and loaded as pointer.
// - Write transfer: count byte follows index and is acknowledged.
// - Count data bytes stored at ascending indices, each acknowledged.
// - Read: repeated start with read bit is acknowledged, pointer kept.
// - First byte sent on a read is the readback count.
// - Register contents follow in ascending index order from the start index.
// - Count programmed to X lets the host read registers 0 to X; here it is only sent as the first read byte and reads run on past X.
// - Register 0 bits 7:6 read the strap-captured mode, never overridden.
// - Register 0 bit 3 picks strap or software mode, resets to 0.
// - Register 0 bits 2:1 give software mode, same code, reset to 3.
// - Enable bits in registers 1 and 2; zero forces pair low, reset 1.
// - Register 7 bits 4:0 hold the readback count, default 8.
module buf_ctrl_top (
    // Clocks and reset
    input  wire logic       ref_clk_i,
    input  wire logic       link_clk_i,
    input  wire logic       sys_rst_i,
    // Serial control port
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output wire logic       sda_o,
    output wire logic       sda_oe_n_o,
    // Pins
    input  wire logic [1:0] loop_mode_strap_pin_i,
    input  wire logic [5:0] out_enable_n_i,
    input  wire logic       warm_rst_i,
    // Outputs
    output wire logic [5:0] differential_output_pair_p_o,
    output wire logic [5:0] differential_output_pair_n_o,
    output wire logic [1:0] loop_mode_o
);
    import buf_ctrl_pkg::*;

    // Link domain
    logic        scl_s1_r, scl_s2_r, scl_d_r;
    logic        sda_s1_r, sda_s2_r, sda_d_r;
    logic [1:0]  strap_s1_r, strap_s2_r, strap_r;
    logic [1:0]  strap_cnt_r;
    logic        strap_done_r;
    link_state_e state_r;
    rx_phase_e   ph_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shreg_r;
    logic [7:0]  ptr_r;
    logic [7:0]  wleft_r;
    logic        rd_r;
    logic        sda_oe_n_r;
    logic        loop_mode_software_override_r;
    logic [1:0]  mode_sw_r;
    logic [5:0]  en_r;
    logic [4:0]  bcnt_r;

    wire scl_rise = scl_s2_r && !scl_d_r;
    wire scl_fall = !scl_s2_r && scl_d_r;
    wire start    = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    wire stop     = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
    wire rx_done  = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_BYTE);
    wire addr_hit = shreg_r[7:1] == SLAVE_ADDR;
    wire wr_stb   = rx_done && (ph_r == PH_WDATA) && (wleft_r != 8'h00);
    wire tx_next  = (state_r == ST_HACK) && scl_fall;
    wire [7:0] cnt_byte = {3'h0, bcnt_r};
    // Readback images
    wire [7:0] reg0 = {strap_r, 2'h0, loop_mode_software_override_r, mode_sw_r, 1'b0};
    wire [7:0] reg1 = EN_LO_RSV | {1'b0, en_r[3], en_r[2], 2'h0, en_r[1], en_r[0], 1'b0};
    wire [7:0] reg2 = EN_HI_RSV | {5'h00, en_r[5], en_r[4], 1'b0};
    wire [7:0] rd_data = (ptr_r == IDX_MODE)  ? reg0 :
                         (ptr_r == IDX_EN_LO) ? reg1 :
                         (ptr_r == IDX_EN_HI) ? reg2 :
                         (ptr_r == IDX_BCNT)  ? cnt_byte : 8'h00;
    wire [1:0] eff_mode = loop_mode_software_override_r ? mode_sw_r : strap_r;

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    // Strap caught once after reset release, after the synchroniser settles
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strap_s1_r   <= MODE_BYPASS;
            strap_s2_r   <= MODE_BYPASS;
            strap_r      <= MODE_BYPASS;
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            strap_s1_r <= loop_mode_strap_pin_i;
            strap_s2_r <= strap_s1_r;
            if (!strap_done_r) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
                if (strap_cnt_r == STRAP_SETTLE) begin
                    strap_r      <= strap_s2_r;
                    strap_done_r <= 1'b1;
                end
            end
        end
    end

    // Protocol engine: sample on rising, drive on falling serial clock
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r    <= ST_IDLE;
            ph_r       <= PH_ADDR;
            bit_cnt_r  <= 4'h0;
            shreg_r    <= 8'h00;
            ptr_r      <= 8'h00;
            wleft_r    <= 8'h00;
            rd_r       <= 1'b0;
            sda_oe_n_r <= 1'b1;
        end else if (start) begin
            state_r    <= ST_RX;
            ph_r       <= PH_ADDR;
            bit_cnt_r  <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end else if (stop) begin
            state_r    <= ST_IDLE;
            sda_oe_n_r <= 1'b1;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_rise) begin
                        shreg_r   <= {shreg_r[6:0], sda_s2_r};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (rx_done) begin
                        state_r    <= ST_ACK;
                        sda_oe_n_r <= 1'b0;
                        case (ph_r)
                            PH_ADDR: begin
                                if (addr_hit) begin
                                    rd_r <= shreg_r[0];
                                    ph_r <= PH_INDEX;
                                end else begin
                                    state_r    <= ST_IDLE;
                                    sda_oe_n_r <= 1'b1;
                                end
                            end
                            PH_INDEX: begin
                                ptr_r <= shreg_r;
                                ph_r  <= PH_COUNT;
                            end
                            PH_COUNT: begin
                                wleft_r <= shreg_r;
                                ph_r    <= PH_WDATA;
                            end
                            default: begin
                                if (wr_stb) begin
                                    ptr_r   <= ptr_r + 8'h01;
                                    wleft_r <= wleft_r - 8'h01;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rd_r) begin
                            state_r    <= ST_TX;
                            shreg_r    <= cnt_byte;
                            sda_oe_n_r <= cnt_byte[7];
                        end else begin
                            state_r    <= ST_RX;
                            sda_oe_n_r <= 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == BIT_LAST_TX) begin
                            state_r    <= ST_HACK;
                            bit_cnt_r  <= 4'h0;
                            sda_oe_n_r <= 1'b1;
                        end else begin
                            shreg_r    <= {shreg_r[6:0], 1'b0};
                            bit_cnt_r  <= bit_cnt_r + 4'h1;
                            sda_oe_n_r <= shreg_r[6];
                        end
                    end
                end
                ST_HACK: begin
                    if (scl_rise && sda_s2_r) begin
                        state_r <= ST_IDLE;
                    end else if (tx_next) begin
                        state_r    <= ST_TX;
                        shreg_r    <= rd_data;
                        sda_oe_n_r <= rd_data[7];
                        ptr_r      <= ptr_r + 8'h01;
                    end
                end
                default: begin
                    sda_oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    // Register writes keep read-only and reserved bits
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            loop_mode_software_override_r <= OVR_RST;
            mode_sw_r <= SW_RST;
            en_r      <= EN_RST;
            bcnt_r    <= BCNT_RST;
        end else if (wr_stb) begin
            if (ptr_r == IDX_MODE) begin
                loop_mode_software_override_r <= shreg_r[BIT_OVR];
                mode_sw_r <= shreg_r[BIT_SW_HI:BIT_SW_LO];
            end else if (ptr_r == IDX_EN_LO) begin
                en_r[3:0] <= {shreg_r[EN3_POS], shreg_r[EN2_POS],
                              shreg_r[EN1_POS], shreg_r[EN0_POS]};
            end else if (ptr_r == IDX_EN_HI) begin
                en_r[5:4] <= {shreg_r[EN5_POS], shreg_r[EN4_POS]};
            end else if (ptr_r == IDX_BCNT) begin
                bcnt_r <= shreg_r[BCNT_W-1:0];
            end
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_n_o = sda_oe_n_r;
    // Ref domain: enables and mode are quasi-static levels, two flops each
    logic [5:0] en_s1_r, en_s2_r;
    logic [1:0] mode_s1_r, mode_s2_r;
    logic       warm_s1_r, warm_s2_r;
    logic [1:0] loop_mode_r;
    logic       phase_r;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_s1_r   <= EN_RST;
            en_s2_r   <= EN_RST;
            mode_s1_r <= MODE_BYPASS;
            mode_s2_r <= MODE_BYPASS;
            warm_s1_r <= 1'b0;
            warm_s2_r <= 1'b0;
            phase_r   <= 1'b0;
        end else begin
            en_s1_r   <= en_r;
            en_s2_r   <= en_s1_r;
            mode_s1_r <= eff_mode;
            mode_s2_r <= mode_s1_r;
            warm_s1_r <= warm_rst_i;
            warm_s2_r <= warm_s1_r;
            phase_r   <= !phase_r;
        end
    end

    // Mode only applied while warm reset is held, never mid-operation
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            loop_mode_r <= MODE_BYPASS;
        end else if (warm_s2_r) begin
            loop_mode_r <= mode_s2_r;
        end
    end
    assign loop_mode_o = loop_mode_r;
    pair_if pairs [6] ();
    generate
        for (genvar i = 0; i < 6; i++) begin : g_pair
            out_pair_gate u_gate (
                .ref_clk_i      (ref_clk_i),
                .sys_rst_i      (sys_rst_i),
                .reg_enable_i   (en_s2_r[i]),
                .enable_n_pin_i (out_enable_n_i[i]),
                .phase_i        (phase_r),
                .pair           (pairs[i])
            );
            assign differential_output_pair_p_o[i] = pairs[i].p;
            assign differential_output_pair_n_o[i] = pairs[i].n;
        end
    endgenerate
    a_addr_ack_drive: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (rx_done && !start && !stop && ph_r == PH_ADDR && addr_hit)
        |=> (state_r == ST_ACK && !sda_oe_n_r))
        else $error("matching address not acknowledged");
    a_addr_miss_idle: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (rx_done && !start && !stop && ph_r == PH_ADDR && !addr_hit)
        |=> (state_r == ST_IDLE && sda_oe_n_r))
        else $error("foreign address acknowledged");
    a_index_load: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (rx_done && !start && !stop && ph_r == PH_INDEX)
        |=> (ptr_r == $past(shreg_r) && ph_r == PH_COUNT && !sda_oe_n_r))
        else $error("start index not loaded");
    a_count_ack: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (rx_done && !start && !stop && ph_r == PH_COUNT)
        |=> (wleft_r == $past(shreg_r) && !sda_oe_n_r))
        else $error("count byte not taken");
    a_write_step: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (wr_stb && !start && !stop)
        |=> (ptr_r == $past(ptr_r) + 8'h01 && wleft_r == $past(wleft_r) - 8'h01))
        else $error("write pointer did not advance");
    a_count_first: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (state_r == ST_ACK && scl_fall && rd_r && !start && !stop)
        |=> (state_r == ST_TX && shreg_r == {3'h0, bcnt_r}))
        else $error("count byte not sent first");
    a_read_ascend: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (tx_next && !start && !stop && !(scl_rise && sda_s2_r))
        |=> (shreg_r == $past(rd_data) && ptr_r == $past(ptr_r) + 8'h01))
        else $error("read data out of order");
    a_strap_held: assert property (
        @(posedge link_clk_i) disable iff (sys_rst_i)
        strap_done_r |=> $stable(strap_r))
        else $error("strap readback changed");
    a_mode_applied: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !warm_s2_r |=> $stable(loop_mode_r))
        else $error("mode changed without warm reset");
endmodule : buf_ctrl_top

// ==== hdl/out_pair_gate.sv ====
// One output pair: enable pin synchroniser and forced-low gating.
// Assumes reg_enable_i is already in the ref_clk_i domain.
`timescale 1ns/1ps
module out_pair_gate (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // Controls
    input  wire logic reg_enable_i,
    input  wire logic enable_n_pin_i,
    input  wire logic phase_i,
    // Pair
    pair_if.drv       pair
);
    logic pin_s1_r;
    logic pin_s2_r;
    logic p_r;
    logic n_r;
    wire  run = reg_enable_i && !pin_s2_r;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= enable_n_pin_i;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Both legs low unless register bit and pin both allow
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            p_r <= 1'b0;
            n_r <= 1'b0;
        end else begin
            p_r <= run && phase_i;
            n_r <= run && !phase_i;
        end
    end

    assign pair.p = p_r;
    assign pair.n = n_r;

    a_pair_forced_low: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !reg_enable_i |=> (!pair.p && !pair.n))
        else $error("pair not low while disabled");

    a_pair_runs: assert property (
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        run |=> (pair.p != pair.n))
        else $error("enabled pair not complementary");
endmodule : out_pair_gate

// ==== hdl/pair_if.sv ====
// Carries one differential output pair between the gate and the top.
// Assumes both legs are plain single-ended levels.
`timescale 1ns/1ps
interface pair_if;
    logic p;
    logic n;
    modport drv  (output p, output n);
    modport sink (input p, input n);
endinterface : pair_if

// ==== test/smb_host_model.sv ====
// Serial control host model: start, stop, byte write and byte read.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module smb_host_model (
    // Timing clock
    input  wire logic       clk_i,
    // Bus pins
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_low_o,
    // Result stream
    output logic [7:0]      res_o,
    output logic            res_stb_o
);
    localparam int PH = 10; // Third of a bit; keeps each scl phase above four link periods
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
        res_o     = 8'h00;
        res_stb_o = 1'b0;
    end
    task automatic hold();
        repeat (PH) @(negedge clk_i);
    endtask : hold
    task automatic post(input logic [7:0] v);
        res_o     = v;
        res_stb_o = 1'b1;
        @(negedge clk_i);
        res_stb_o = 1'b0;
    endtask : post
    task automatic bit_tx(input logic b);
        hold();
        sda_low_o = ~b;
        hold();
        scl_o = 1'b1;
        hold();
        scl_o = 1'b0;
    endtask : bit_tx
    task automatic bit_rx(output logic b);
        hold();
        sda_low_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        b     = sda_i;
        scl_o = 1'b0;
    endtask : bit_rx
    task automatic start();
        hold();
        sda_low_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_low_o = 1'b1;
        hold();
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        hold();
        sda_low_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_low_o = 1'b0;
        hold();
    endtask : stop
    task automatic wbyte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) bit_tx(v[i]);
        bit_rx(a);
        post({7'h00, a});
    endtask : wbyte
    task automatic rbyte(input logic last);
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) bit_rx(v[i]);
        bit_tx(last);
        post(v);
    endtask : rbyte
endmodule : smb_host_model

// ==== test/tb.sv ====
// Self-checking bench: serial register access, output pairs, loop mode.
// Assumes smb_host_model and buf_ctrl_pkg are compiled first.
`timescale 1ns/1ps
module tb;
    import buf_ctrl_pkg::*;
    logic       ref_clk  = 1'b0;
    logic       link_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       warm_rst = 1'b0;
    logic [1:0] strap    = MODE_LO_BW;
    logic [5:0] pins_n   = 6'h00;
    logic       scl, host_low, sda_oe_n, sda_out, res_stb;
    wire        sda_w;
    logic [5:0] pair_p, pair_n;
    logic [1:0] mode;
    logic [7:0] res, r1, r2, e1, e2, exp_v;
    logic [7:0] exp_q[$];
    logic [1:0] codes[3] = '{MODE_LO_BW, MODE_BYPASS, MODE_HI_BW};
    int         err_total = 0;
    int         check_count = 0;
    int         seed = 32'h9749E8E5;
    always #4 ref_clk = ~ref_clk;
    always #7.5 link_clk = ~link_clk;
    // Open-drain wire with pull-up
    assign sda_w = ~(host_low | (~sda_oe_n & ~sda_out));
    buf_ctrl_top uut (.ref_clk_i(ref_clk), .link_clk_i(link_clk), .sys_rst_i(sys_rst),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_n_o(sda_oe_n),
        .loop_mode_strap_pin_i(strap), .out_enable_n_i(pins_n), .warm_rst_i(warm_rst),
        .differential_output_pair_p_o(pair_p), .differential_output_pair_n_o(pair_n),
        .loop_mode_o(mode));
    smb_host_model host (.clk_i(ref_clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low),
        .res_o(res), .res_stb_o(res_stb));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (exp_q.size() != 0) err_total++;
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [7:0] r0(input logic [1:0] sw, input logic ovr);
        r0 = {strap, 2'b00, ovr, sw, 1'b0};
    endfunction : r0
    function automatic logic [5:0] en_of(input logic [7:0] a, input logic [7:0] b);
        en_of = {b[EN5_POS], b[EN4_POS], a[EN3_POS], a[EN2_POS], a[EN1_POS], a[EN0_POS]};
    endfunction : en_of
    task automatic chk_pairs(input logic [5:0] want);
        logic [5:0] p1;
        repeat (10) @(negedge ref_clk);
        p1 = pair_p;
        @(negedge ref_clk);
        check("toggling", {2'b00, (p1 ^ pair_p) & (pair_p ^ pair_n)}, {2'b00, want});
        check("held_low", {2'b00, (p1 | pair_p | pair_n) & ~want}, 8'h00);
    endtask : chk_pairs
    task automatic warm();
        warm_rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        warm_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : warm
    task automatic wr_block(input logic [7:0] idx, input logic [7:0] cnt, input logic [7:0] d[$]);
        repeat (3 + d.size()) exp_q.push_back(8'h00);
        host.start();
        host.wbyte({SLAVE_ADDR, 1'b0});
        host.wbyte(idx);
        host.wbyte(cnt);
        foreach (d[i]) host.wbyte(d[i]);
        host.stop();
    endtask : wr_block
    task automatic rd_block(input logic [7:0] idx, input logic [7:0] e[$]);
        repeat (3) exp_q.push_back(8'h00);
        foreach (e[i]) exp_q.push_back(e[i]);
        host.start();
        host.wbyte({SLAVE_ADDR, 1'b0});
        host.wbyte(idx);
        host.start();
        host.wbyte({SLAVE_ADDR, 1'b1});
        foreach (e[i]) host.rbyte(i == e.size() - 1);
        host.stop();
    endtask : rd_block
    // Oldest note against each result from the host
    always @(posedge ref_clk) begin
        if (res_stb === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            check("serial", res, exp_v);
        end
    end
    initial begin
        #500000;
        err_total++;
        print_verdict();
    end
    initial begin
        strap  = codes[$unsigned($random(seed)) % 3];
        pins_n = 6'($random(seed));
        r1     = 8'($random(seed));
        r2     = 8'($random(seed));
        e1     = r1 & 8'h66 | EN_LO_RSV;
        e2     = r2 & 8'h06 | EN_HI_RSV;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        warm();
        check("mode", {6'h00, mode}, {6'h00, strap});
        chk_pairs(~pins_n);
        rd_block(8'h00, '{8'h08, r0(SW_RST, OVR_RST), 8'hFF, 8'h0E, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h08, 8'h00});
        exp_q.push_back(8'h01);
        host.start();
        host.wbyte({~SLAVE_ADDR, 1'b0});
        host.stop();
        // Extra byte past the count must be acked but not stored
        wr_block(8'h00, 8'h04, '{8'hFB, r1, r2, 8'hFF, 8'hAA});
        check("mode", {6'h00, mode}, {6'h00, strap});
        pins_n = 6'($random(seed));
        chk_pairs(en_of(r1, r2) & ~pins_n);
        wr_block(8'h07, 8'h01, '{8'hE2});
        rd_block(8'h00, '{8'h02, r0(MODE_BYPASS, 1'b1), e1, e2});
        // Runs on into the spare register, which was written with all ones
        rd_block(8'h01, '{8'h02, e1, e2, 8'h00});
        foreach (codes[i]) begin
            wr_block(8'h00, 8'h01, '{{4'h0, 1'b1, codes[i], 1'b0}});
            warm();
            check("mode", {6'h00, mode}, {6'h00, codes[i]});
            rd_block(8'h00, '{8'h02, r0(codes[i], 1'b1)});
        end
        repeat (20) @(negedge ref_clk);
        print_verdict();
    end
endmodule : tb
